// [counter_readout_defs.svh]
// Functional notes
// - read opcode returns latest first-phase status
// - successful counter request delivers tag, counter, signature
// - error flags make result fields meaningless
// - early chip-select rise ends read cleanly
// - payload is 49 bytes; beyond is undefined
// - busy repeats status byte from second payload byte
// - busy hides fields; controller rereads afterwards
// - reserved command type sets status bit 2
// - signature message is tag then counter
`ifndef COUNTER_READOUT_DEFS_SVH
`define COUNTER_READOUT_DEFS_SVH
`define RD_OPCODE         8'h96
`define PAYLOAD_BYTES     49
`define TAG_FIRST_BYTE    1
`define CTR_FIRST_BYTE    13
`define SIG_FIRST_BYTE    17
`define STAT_BUSY_BIT     0
`define STAT_RSVD_BIT     2
`define STAT_ERR_MASK     8'hFE
`define STAT_RESET        8'h00
`endif

// [counter_readout_pkg.sv]
package counter_readout_pkg;
  // result of the last first-phase command, held by the counter engine
  typedef struct packed {
    logic [7:0]   status;
    logic         was_request;
    logic [95:0]  tag;
    logic [31:0]  counter;
    logic [255:0] signature;
  } engine_result_t;

  typedef enum logic [1:0] {
    ST_OPCODE = 2'b00,
    ST_DUMMY  = 2'b01,
    ST_DATA   = 2'b10,
    ST_IGNORE = 2'b11
  } read_state_t;
endpackage

// [counter_status_readout.sv]
`timescale 1ns/1ps
`include "counter_readout_defs.svh"

module counter_status_readout
(
  // core domain
  input  wire logic                                core_clk,
  input  wire logic                                sys_rst,
  input  wire counter_readout_pkg::engine_result_t engine_result,
  input  wire logic                                reserved_cmd,
  // serial link
  input  wire logic                                sck,
  input  wire logic                                cs_n,
  input  wire logic                                mosi,
  output logic                                     miso,
  output logic                                     miso_oe,
  output logic                                     read_active
);

  // ---------------------------------------------------------------------
  // core domain: status capture
  // ---------------------------------------------------------------------
  // reserved flag sticks until the engine result status changes
  logic [7:0] status_r;
  logic       rsvd_r;
  logic       rsvd_nxt;
  assign rsvd_nxt = reserved_cmd ? 1'b1 :
                    (engine_result.status != status_r) ? 1'b0 : rsvd_r;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      status_r <= `STAT_RESET;
      rsvd_r   <= 1'b0;
    end
    else
    begin
      status_r <= engine_result.status;
      rsvd_r   <= rsvd_nxt;
    end
  end

  // status byte seen by the reader, bit 2 on reserved command
  logic [7:0] status_view;
  always_comb
  begin
    status_view = status_r;
    status_view[`STAT_RSVD_BIT] = status_r[`STAT_RSVD_BIT] | rsvd_r;
  end

  // ---------------------------------------------------------------------
  // link domain
  // ---------------------------------------------------------------------
  // status and results are quasi-static; two flops per bit on sck
  logic [7:0]   stat_s1_r;
  logic [7:0]   stat_s2_r;
  counter_readout_pkg::engine_result_t res_s1_r;
  counter_readout_pkg::engine_result_t res_s2_r;
  always_ff @(posedge sck)
  begin
    stat_s1_r <= status_view;
    stat_s2_r <= stat_s1_r;
    res_s1_r  <= engine_result;
    res_s2_r  <= res_s1_r;
  end

  // frame state, cleared asynchronously by chip select high
  counter_readout_pkg::read_state_t state_r;
  logic [2:0] bit_r;
  logic [5:0] byte_r;
  logic [7:0] shift_in_r;
  logic [7:0] out_byte_r;
  logic [7:0] stat_lat_r;
  logic       busy_lat_r;

  // pick payload byte by index, most significant first
  function automatic logic [7:0] pick_byte(
    input logic [5:0] idx,
    input logic [7:0] st,
    input counter_readout_pkg::engine_result_t r);
    logic [391:0] flat;
    flat = {st, r.tag, r.counter, r.signature};
    pick_byte = flat[391 - 8*idx -: 8];
  endfunction

  // next byte to present: status first and while busy, zeros on error
  logic [7:0] next_byte;
  logic       fields_ok;
  assign fields_ok = !busy_lat_r && res_s2_r.was_request &&
                     ((stat_lat_r & `STAT_ERR_MASK) == 8'h00);
  always_comb
  begin
    if (byte_r == 6'h00)
      next_byte = stat_lat_r;
    else if (busy_lat_r)
      next_byte = stat_lat_r;
    else if (byte_r >= 6'(`PAYLOAD_BYTES))
      next_byte = 8'h00;
    else if (fields_ok)
      next_byte = pick_byte(byte_r, stat_lat_r, res_s2_r);
    else
      next_byte = 8'h00;
  end

  // input side: opcode and dummy byte on rising edge
  always_ff @(posedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      state_r    <= counter_readout_pkg::ST_OPCODE;
      bit_r      <= 3'h0;
      byte_r     <= 6'h00;
      shift_in_r <= 8'h00;
      stat_lat_r <= 8'h00;
      busy_lat_r <= 1'b0;
    end
    else
    begin
      bit_r      <= bit_r + 3'h1;
      shift_in_r <= {shift_in_r[6:0], mosi};
      unique case (state_r)
        counter_readout_pkg::ST_OPCODE:
          if (bit_r == 3'h7)
          begin
            state_r <= ({shift_in_r[6:0], mosi} == `RD_OPCODE) ?
                       counter_readout_pkg::ST_DUMMY :
                       counter_readout_pkg::ST_IGNORE;
            stat_lat_r <= stat_s2_r;
            busy_lat_r <= stat_s2_r[`STAT_BUSY_BIT];
          end
        counter_readout_pkg::ST_DUMMY:
          if (bit_r == 3'h7)
            state_r <= counter_readout_pkg::ST_DATA;
        counter_readout_pkg::ST_DATA:
          if (bit_r == 3'h7 && byte_r != 6'h3F)
            byte_r <= byte_r + 6'h01;
        counter_readout_pkg::ST_IGNORE: ;
      endcase
    end
  end

  // output side: shift on falling edge, load at byte boundary
  always_ff @(negedge sck or posedge cs_n)
  begin
    if (cs_n)
      out_byte_r <= 8'h00;
    else if (state_r == counter_readout_pkg::ST_DATA)
      out_byte_r <= (bit_r == 3'h0) ? next_byte
                                    : {out_byte_r[6:0], 1'b0};
  end

  assign miso        = out_byte_r[7];
  assign miso_oe     = !cs_n && (state_r == counter_readout_pkg::ST_DATA);
  assign read_active = miso_oe;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  property p_busy_repeat;
    @(negedge sck) disable iff (cs_n)
      (state_r == counter_readout_pkg::ST_DATA && busy_lat_r &&
       bit_r == 3'h0) |=> (out_byte_r == stat_lat_r);
  endproperty
  a_busy_repeat: assert property (p_busy_repeat)
    else $error("busy status not repeated");

  property p_error_blank;
    @(negedge sck) disable iff (cs_n)
      (state_r == counter_readout_pkg::ST_DATA && byte_r != 6'h00 &&
       !busy_lat_r && (stat_lat_r & `STAT_ERR_MASK) != 8'h00 &&
       bit_r == 3'h0) |=> (out_byte_r == 8'h00);
  endproperty
  a_error_blank: assert property (p_error_blank)
    else $error("fields shown despite error");

  property p_first_status;
    @(negedge sck) disable iff (cs_n)
      (state_r == counter_readout_pkg::ST_DATA && byte_r == 6'h00 &&
       bit_r == 3'h0) |=> (out_byte_r == stat_lat_r);
  endproperty
  a_first_status: assert property (p_first_status)
    else $error("first byte not status");

  property p_rsvd_bit;
    @(posedge core_clk) disable iff (sys_rst)
      reserved_cmd |=> status_view[`STAT_RSVD_BIT];
  endproperty
  a_rsvd_bit: assert property (p_rsvd_bit)
    else $error("reserved command not flagged");

  property p_no_drive_idle;
    @(posedge core_clk) disable iff (sys_rst)
      cs_n |-> (!miso_oe && !miso);
  endproperty
  a_no_drive_idle: assert property (p_no_drive_idle)
    else $error("output driven with chip select high");

  // byte load point: data phase, first bit of a byte
  sequence s_byte_load;
    state_r == counter_readout_pkg::ST_DATA && bit_r == 3'h0;
  endsequence

  // past the payload the output is held at zero unless busy
  property p_past_payload;
    @(negedge sck) disable iff (cs_n)
      (s_byte_load ##0 (!busy_lat_r && byte_r >= 6'(`PAYLOAD_BYTES)))
        |=> (out_byte_r == 8'h00);
  endproperty
  a_past_payload: assert property (p_past_payload)
    else $error("data driven past payload");

  // latched status stands for the whole data phase
  property p_latch_hold;
    @(negedge sck) disable iff (cs_n)
      (state_r == counter_readout_pkg::ST_DATA) |-> $stable(stat_lat_r);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latched status changed within frame");

endmodule // counter_status_readout

// [spi_host.sv]
`timescale 1ns/1ps

// ---
// controller model
// ---
module spi_host
(
  // serial link
  output logic      sck,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  logic [7:0] rx [0:63];

  // idle link: deselected, clock still
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // opcode, dummy, then n bytes; bytes past the payload are dropped
  task automatic frame(input logic [7:0] op, input int n);
    logic [7:0] tx;
    cs_n = 1'b0;
    for (int b = 0; b < n + 2; b++)
    begin
      tx = (b == 0) ? op : 8'h00;
      for (int i = 7; i >= 0; i--)
      begin
        mosi = tx[i];
        #6 sck = 1'b1;
        if (b > 1 && b < 51)
          rx[b-2][i] = miso;
        #6 sck = 1'b0;
      end
    end
    #6 cs_n = 1'b1;
    mosi = ~mosi;
    #12;
  endtask
endmodule // spi_host

// [counter_status_readout_test.sv]
`timescale 1ns/1ps

// ---
// bench
// ---
module counter_status_readout_test;
  typedef struct packed {
    logic [7:0] st;
    logic       req;
  } row_t;
  localparam row_t ROWS [0:4] = '{'{8'h00, 1'h1}, '{8'h01, 1'h1},
    '{8'h20, 1'h1}, '{8'h00, 1'h0}, '{8'h81, 1'h1}};

  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reserved_cmd = 1'b0;
  counter_readout_pkg::engine_result_t res;
  logic sck, cs_n, mosi, miso, miso_oe, oe_seen;
  int   n_mismatch = 0;
  int   checks = 0;

  always #5 core_clk = ~core_clk;
  // notes any drive of the output
  always @(posedge miso_oe) oe_seen = 1'b1;

  counter_status_readout dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .engine_result(res), .reserved_cmd(reserved_cmd), .sck(sck),
    .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .read_active());
  spi_host host (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  task automatic cmp(string what, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // apply a status, read n bytes, compare the payload
  task automatic run(logic [7:0] st, logic [7:0] e, logic req, int n);
    logic [391:0] pay;
    logic         ok;
    @(negedge core_clk);
    res.status = st;
    res.was_request = req;
    ok = !e[0] && req && !(e & 8'hFE);
    pay = {e, ok ? {res.tag, res.counter, res.signature} : 384'h0};
    oe_seen = 1'b0;
    host.frame(8'h96, n);
    cmp("drive", 8'h01, {7'h00, oe_seen});
    for (int k = 0; k < n && k < 49; k++)
      cmp("byte", e[0] ? e : pay[391-8*k -: 8], host.rx[k]);
    $display("test status %h done", e);
  endtask

  // cut a hang short
  initial
  begin
    #500000;
    n_mismatch++;
    conclude();
  end

  // rows, then early end, reserved type and foreign opcode
  initial
  begin
    res = '0;
    res.tag = {3{32'h5A17C0DE}};
    res.counter = 32'hFFFFFFFE;
    res.signature = {8{32'hA5C30F1E}};
    repeat (3) @(negedge core_clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 5; i++)
      run(ROWS[i].st, ROWS[i].st, ROWS[i].req, 50);
    run(8'h00, 8'h00, 1'b1, 1);
    run(8'h00, 8'h00, 1'b1, 17);
    @(negedge core_clk);
    reserved_cmd = 1'b1;
    @(negedge core_clk);
    reserved_cmd = 1'b0;
    run(8'h00, 8'h04, 1'b1, 17);
    oe_seen = 1'b0;
    host.frame(8'h03, 2);
    cmp("idle", 8'h00, {7'h00, oe_seen});
    $display("test foreign opcode done");
    // mid-run reset clears the reserved flag
    @(negedge core_clk);
    sys_rst = 1'b1;
    repeat (3) @(negedge core_clk);
    sys_rst = 1'b0;
    run(8'h00, 8'h00, 1'b1, 17);
    conclude();
  end
endmodule // counter_status_readout_test
